// >>> hw/rnpc_ctrl.sv
`include "rnpc_cfg.svh"

// How it works
// - Reset input low long enough resets device
// - Bidirectional mode pulls reset line during sequence
// - Indication output low on any reset
// - Indication released only by end-of-init
// - Falling interrupt edge raises trap request
// - Config 0: power-down only if interrupt low
// - Config 0: interrupt high ignores power-down
// - Timing pin picks reset mode, wake delay
module rnpc_ctrl
    import rnpc_pkg::*;
#(
    parameter int RST_MIN_CYC = `RNPC_RST_MIN_CYC,
    parameter int RST_SEQ_CYC = `RNPC_RST_SEQ_CYC
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    // Reset pin, two-way open drain
    input  wire logic            reset_in_n,
    output logic                 reset_in_n_o,
    output logic                 reset_in_n_oe,
    // Indication pin
    output logic                 reset_indication_out_n,
    // Interrupt and timing pins
    input  wire logic            nmi_n,
    input  wire logic            powerdown_timing_pin,
    // Configuration bits
    input  wire logic            bidir_reset_enable,
    input  wire logic            powerdown_config_bit,
    // Core requests
    input  wire rnpc_rst_req_s   rst_req,
    input  wire rnpc_instr_s     instr,
    input  wire logic            wake_req,
    // Status towards core
    output logic                 core_reset,
    output logic                 nmi_trap,
    output logic                 powerdown_active,
    output logic                 async_reset_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [2:0] pins_sync;
    logic       rst_pin_s;
    logic       nmi_s;
    logic       pd_timing_s;

    rnpc_sync #(
        .WIDTH    (3)
    ) u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .async_in ({reset_in_n, nmi_n, powerdown_timing_pin}),
        .sync_out (pins_sync)
    );

    assign rst_pin_s   = pins_sync[2];
    assign nmi_s       = pins_sync[1];
    assign pd_timing_s = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////
    // Reset pin filter and interrupt edge
    logic [`RNPC_CNT_W-1:0] low_cnt;
    logic [`RNPC_CNT_W-1:0] next_low_cnt;
    logic                   nmi_prev;
    logic                   next_nmi_prev;
    logic                   next_nmi_trap;
    logic                   pin_reset;
    logic                   driving;

    // Counts low time; own drive of the pin is not a request
    always_comb begin
        next_low_cnt  = low_cnt;
        if (rst_pin_s || driving) begin
            next_low_cnt = '0;
        end else if (low_cnt != `RNPC_CNT_W'(RST_MIN_CYC)) begin
            next_low_cnt = low_cnt + `RNPC_CNT_W'(1);
        end
        next_nmi_prev = nmi_s;
        next_nmi_trap = nmi_prev && !nmi_s;
    end

    assign pin_reset = (low_cnt == `RNPC_CNT_W'(RST_MIN_CYC));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            low_cnt  <= '0;
            nmi_prev <= 1'h1;
            nmi_trap <= 1'h0;
        end else begin
            low_cnt  <= next_low_cnt;
            nmi_prev <= next_nmi_prev;
            nmi_trap <= next_nmi_trap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    rnpc_state_e            state;
    rnpc_state_e            next_state;
    logic [`RNPC_CNT_W-1:0] seq_cnt;
    logic [`RNPC_CNT_W-1:0] next_seq_cnt;
    logic                   next_async_reset_mode;
    logic                   any_reset;

    assign any_reset = pin_reset || rst_req.hw || rst_req.sw || rst_req.wdt;

    always_comb begin
        next_state            = state;
        next_seq_cnt          = seq_cnt;
        next_async_reset_mode = async_reset_mode;
        case (state)
            RNPC_RUN: begin
                if (instr.powerdown_instr && (powerdown_config_bit || !nmi_s)) begin
                    next_state = RNPC_POWERDOWN;
                end // else ignored
            end
            RNPC_RESET_SEQ: begin
                if (seq_cnt == `RNPC_CNT_W'(RST_SEQ_CYC - 1)) begin
                    next_state            = RNPC_WAIT_INIT;
                    next_async_reset_mode = !pd_timing_s;
                end else begin
                    next_seq_cnt = seq_cnt + `RNPC_CNT_W'(1);
                end
            end
            RNPC_WAIT_INIT: begin
                if (instr.end_of_init_instr) begin
                    next_state = RNPC_RUN;
                end
            end
            RNPC_POWERDOWN: begin
                if (wake_req || nmi_trap) begin
                    next_state   = RNPC_WAKE;
                    next_seq_cnt = pd_timing_s ? `RNPC_CNT_W'(`RNPC_WAKE_LONG_CYC)
                                               : `RNPC_CNT_W'(`RNPC_WAKE_SHORT_CYC);
                end
            end
            RNPC_WAKE: begin
                if (seq_cnt == '0) begin
                    next_state = RNPC_RUN;
                end else begin
                    next_seq_cnt = seq_cnt - `RNPC_CNT_W'(1);
                end
            end
            default: begin
                next_state = RNPC_RESET_SEQ;
            end
        endcase
        // Any reset restarts the sequence
        if (any_reset) begin
            next_state   = RNPC_RESET_SEQ;
            next_seq_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state            <= RNPC_RESET_SEQ;
            seq_cnt          <= '0;
            async_reset_mode <= 1'h0;
        end else begin
            state            <= next_state;
            seq_cnt          <= next_seq_cnt;
            async_reset_mode <= next_async_reset_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs, registered
    logic next_driving;
    logic next_ind_n;
    logic next_core_reset;
    logic next_pd;

    always_comb begin
        next_driving    = (next_state == RNPC_RESET_SEQ) && bidir_reset_enable;
        next_ind_n      = (next_state == RNPC_RUN) || (next_state == RNPC_POWERDOWN)
                          || (next_state == RNPC_WAKE);
        next_core_reset = (next_state == RNPC_RESET_SEQ);
        next_pd         = (next_state == RNPC_POWERDOWN);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            driving                <= 1'h0;
            reset_indication_out_n <= 1'h0;
            core_reset             <= 1'h1;
            powerdown_active       <= 1'h0;
        end else begin
            driving                <= next_driving;
            reset_indication_out_n <= next_ind_n;
            core_reset             <= next_core_reset;
            powerdown_active       <= next_pd;
        end
    end

    assign reset_in_n_o  = 1'h0;
    assign reset_in_n_oe = driving;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_ind_low_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
        core_reset |-> !reset_indication_out_n) else $error("indication high in reset");
    a_ind_hold_init: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == RNPC_WAIT_INIT && !instr.end_of_init_instr && !any_reset)
        |=> !reset_indication_out_n) else $error("indication released early");
    a_ind_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == RNPC_WAIT_INIT && instr.end_of_init_instr && !any_reset)
        |=> reset_indication_out_n) else $error("indication not released");
    a_bidir_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == RNPC_RESET_SEQ && bidir_reset_enable && $stable(bidir_reset_enable))
        |-> reset_in_n_oe) else $error("reset line not driven");
    a_no_drive_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reset_in_n_oe |-> core_reset) else $error("reset line driven outside sequence");
    a_pin_reset_seq: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pin_reset |=> core_reset && seq_cnt == '0) else $error("pin reset not taken");
    a_nmi_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($past(nmi_s) && !nmi_s) |=> nmi_trap) else $error("trap missed");
    a_pd_enter: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == RNPC_RUN && instr.powerdown_instr && !powerdown_config_bit && !nmi_s
         && !any_reset) |=> powerdown_active) else $error("power-down not entered");
    a_pd_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == RNPC_RUN && instr.powerdown_instr && !powerdown_config_bit && nmi_s)
        |=> !powerdown_active) else $error("power-down not blocked");
    // Interrupt level seen by the logic is the pin two edges late
    a_sync_used: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $changed(nmi_s) |-> nmi_s == $past(nmi_n, 2)) else $error("interrupt level not two flops late");

endmodule

// >>> hw/rnpc_cfg.svh
`ifndef RNPC_CFG_SVH
`define RNPC_CFG_SVH

// Reset input low time, ns, and its cycle count at 50 MHz (rounded up)
`define RNPC_CLK_PERIOD_NS      20
`define RNPC_RST_MIN_NS         1000
`define RNPC_RST_MIN_CYC        ((`RNPC_RST_MIN_NS + `RNPC_CLK_PERIOD_NS - 1) / `RNPC_CLK_PERIOD_NS)
// Internal reset sequence length in cycles
`define RNPC_RST_SEQ_CYC        64
// Power-down wake delay selected by the timing pin, in cycles
`define RNPC_WAKE_LONG_CYC      32
`define RNPC_WAKE_SHORT_CYC     4
// Counter width
`define RNPC_CNT_W              8
// Synchroniser reset level (pins idle high)
`define RNPC_SYNC_RST           1'h1

`endif

// >>> hw/rnpc_pkg.sv
package rnpc_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        RNPC_RUN,
        RNPC_RESET_SEQ,
        RNPC_WAIT_INIT,
        RNPC_POWERDOWN,
        RNPC_WAKE
    } rnpc_state_e;

    // Reset cause requests from the core
    typedef struct packed {
        logic hw;
        logic sw;
        logic wdt;
    } rnpc_rst_req_s;

    // Core instruction strobes
    typedef struct packed {
        logic end_of_init_instr;
        logic powerdown_instr;
    } rnpc_instr_s;

    // Reset pin drive, value and enable
    typedef struct packed {
        logic o;
        logic oe;
    } rnpc_pin_drive_s;

endpackage

// >>> hw/rnpc_sync.sv
`include "rnpc_cfg.svh"

module rnpc_sync
    import rnpc_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    // Two-flop chain, stage1 read only by sync_out
    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1   <= {WIDTH{`RNPC_SYNC_RST}};
            sync_out <= {WIDTH{`RNPC_SYNC_RST}};
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule

// >>> verif/rnpc_ext_model.sv
module rnpc_ext_model
    import rnpc_pkg::*;
(
    // Clock
    input  wire logic clk_sys,
    // Commands from the bench
    input  wire logic cmd_pull,
    input  wire logic cmd_nmi,
    input  wire logic cmd_pin,
    // Device drive of the reset line
    input  wire logic dev_o,
    input  wire logic dev_oe,
    // Pin levels seen by the device
    output logic      reset_line,
    output logic      nmi_n,
    output logic      powerdown_timing_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    logic             ext_pull;

    // Outside circuit changes pins just after an edge; idle levels come from the bench
    always @(posedge clk_sys) begin
        ext_pull <= cmd_pull;
        nmi_n <= cmd_nmi; // Held high while unused
        powerdown_timing_pin <= cmd_pin;
    end

    // Wired-and reset line with pull-up
    assign reset_line = (ext_pull || (dev_oe && !dev_o)) ? 1'h0 : 1'h1;
endmodule

// >>> verif/testbench.sv
`include "rnpc_cfg.svh"

module testbench
    import rnpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys = 1'h0, sys_rst = 1'h1, rst_line, rst_o, rst_oe, ind_n, nmi_n, tpin;
    logic bidir = 1'h0, pdcfg = 1'h0, wake_req = 1'h0, core_reset, nmi_trap, pd_act, amode;
    logic cmd_pull = 1'h0, cmd_nmi = 1'h1, cmd_pin = 1'h1;
    rnpc_rst_req_s rst_req = '0;
    rnpc_instr_s   instr = '0;
    int miscompares = 0, checks_done = 0, n;

    // Clock at 50 MHz
    always #10 clk_sys = ~clk_sys;

    rnpc_ext_model rnpc_ext_model_inst (.clk_sys(clk_sys), .cmd_pull(cmd_pull),
        .cmd_nmi(cmd_nmi), .cmd_pin(cmd_pin), .dev_o(rst_o), .dev_oe(rst_oe),
        .reset_line(rst_line), .nmi_n(nmi_n), .powerdown_timing_pin(tpin));

    rnpc_ctrl #(.RST_MIN_CYC(3), .RST_SEQ_CYC(4)) rnpc_ctrl_inst (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .reset_in_n(rst_line), .reset_in_n_o(rst_o),
        .reset_in_n_oe(rst_oe), .reset_indication_out_n(ind_n), .nmi_n(nmi_n),
        .powerdown_timing_pin(tpin), .bidir_reset_enable(bidir),
        .powerdown_config_bit(pdcfg), .rst_req(rst_req), .instr(instr),
        .wake_req(wake_req), .core_reset(core_reset), .nmi_trap(nmi_trap),
        .powerdown_active(pd_act), .async_reset_mode(amode));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input string name, input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Wait out the sequence, then release indication
    task automatic finish_seq(input logic b, input logic pin);
        n = 0;
        while (core_reset === 1'h1 && n < 100) begin
            check("oe", rst_oe, b);
            check("drive_lvl", rst_o, 1'h0);
            @(negedge clk_sys);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            final_report();
        end
        check("oe_end", rst_oe, 1'h0);
        check("mode", amode, ~pin);
        repeat (3) @(negedge clk_sys);
        check("ind_hold", ind_n, 1'h0);
        @(posedge clk_sys) instr.end_of_init_instr <= 1'h1;
        @(posedge clk_sys) instr.end_of_init_instr <= 1'h0;
        @(negedge clk_sys) check("ind_rel", ind_n, 1'h1);
    endtask

    // Each core reset cause, with and without line drive
    task automatic t_causes();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            bidir <= i[0];
            cmd_pin <= i[1];
            repeat (3) @(posedge clk_sys);
            rst_req <= rnpc_rst_req_s'(3'h4 >> (i / 2));
            @(posedge clk_sys) rst_req <= '0;
            @(negedge clk_sys);
            check("core", core_reset, 1'h1);
            check("ind", ind_n, 1'h0);
            finish_seq(i[0], i[1]);
        end
    endtask

    // Short glitch ignored, long pull resets
    task automatic t_pin();
        @(posedge clk_sys) cmd_pull <= 1'h1;
        @(posedge clk_sys) cmd_pull <= 1'h0;
        repeat (8) @(negedge clk_sys) check("glitch", core_reset, 1'h0);
        @(posedge clk_sys) cmd_pull <= 1'h1;
        repeat (8) @(posedge clk_sys);
        cmd_pull <= 1'h0;
        @(negedge clk_sys) check("pin_rst", core_reset, 1'h1);
        check("pin_ind", ind_n, 1'h0);
        // Line drive on and timing pin low, as the last cause left them
        finish_seq(1'h1, 1'h0);
    endtask

    // Interrupt edge, power-down gating and wake delay
    task automatic t_nmi_pd();
        int exp_n;
        @(posedge clk_sys) cmd_nmi <= 1'h0;
        n = 0;
        repeat (10) @(negedge clk_sys) n += (nmi_trap === 1'h1);
        check("trap_one", n == 1, 1'h1);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys) cmd_pin <= p[0];
            repeat (8) @(posedge clk_sys);
            instr.powerdown_instr <= 1'h1;
            @(posedge clk_sys) instr.powerdown_instr <= 1'h0;
            @(negedge clk_sys) check("pd_in", pd_act, 1'h1);
            @(posedge clk_sys) wake_req <= 1'h1;
            @(posedge clk_sys) wake_req <= 1'h0;
            @(negedge clk_sys) check("pd_out", pd_act, 1'h0);
            // Instruction held: taken only once the wake delay has run out
            @(posedge clk_sys) instr.powerdown_instr <= 1'h1;
            n = 0;
            while (pd_act !== 1'h1 && n < 60) begin
                @(negedge clk_sys);
                n++;
            end
            exp_n = p[0] ? `RNPC_WAKE_LONG_CYC : `RNPC_WAKE_SHORT_CYC;
            check("wake_len", n == exp_n + 2, 1'h1);
            @(posedge clk_sys) instr.powerdown_instr <= 1'h0;
            wake_req <= 1'h1;
            @(posedge clk_sys) wake_req <= 1'h0;
        end
        @(posedge clk_sys) cmd_nmi <= 1'h1;
        n = 0;
        repeat (40) @(negedge clk_sys) n += (nmi_trap === 1'h1);
        check("trap_rise", n == 0, 1'h1);
        @(posedge clk_sys) instr.powerdown_instr <= 1'h1;
        @(posedge clk_sys) instr.powerdown_instr <= 1'h0;
        repeat (4) @(negedge clk_sys) check("pd_ign", pd_act, 1'h0);
        // Config bit set: interrupt level no longer gates entry, trap wakes
        @(posedge clk_sys) pdcfg <= 1'h1;
        @(posedge clk_sys) instr.powerdown_instr <= 1'h1;
        @(posedge clk_sys) instr.powerdown_instr <= 1'h0;
        @(negedge clk_sys) check("pd_cfg", pd_act, 1'h1);
        @(posedge clk_sys) cmd_nmi <= 1'h0;
        repeat (8) @(negedge clk_sys);
        check("pd_trap", pd_act, 1'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys) check("rst_core", core_reset, 1'h1);
        check("rst_ind", ind_n, 1'h0);
        @(posedge clk_sys) sys_rst <= 1'h0;
        @(negedge clk_sys) finish_seq(1'h0, 1'h1);
        t_causes();
        t_pin();
        t_nmi_pd();
        final_report();
    end
endmodule
